// ---- tb/lbh_assertions.sv ----
// Concurrent checks on the wires joining the two ends.
// Assumes both ends share CLK_SYS and RST.
module lbh_assertions (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Bus wires
	input wire logic ad_oe,
	input wire logic [lbh_pkg::LANES-1:0] lane_sel_n,
	input wire logic lane_oe,
	input wire logic addr_strobe_n,
	input wire logic xcvr_en_n,
	input wire logic ctl_oe,
	input wire logic ready_n,
	input wire logic hold_req,
	input wire logic hold_grant,
	input wire logic cacheable_oe,
	input wire logic bus_reset
);
	import lbh_pkg::*;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	////////////////////////////////////////////////////////////////////////
	AST_LANES_CONTIG: assert property (
		!addr_strobe_n && lane_oe |-> ~lane_sel_n inside
		{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf})
		else $error("lane pattern not contiguous");
	AST_CACHE_IDLE: assert property (
		addr_strobe_n && xcvr_en_n |-> !cacheable_oe) else $error("cacheable driven idle");
	AST_HOLD_FLOAT: assert property (
		hold_grant |-> !ad_oe && !lane_oe && !ctl_oe && !cacheable_oe)
		else $error("line driven while granted");
	AST_STROBE_ONE: assert property (
		!addr_strobe_n |=> addr_strobe_n) else $error("strobe held two cycles");
	AST_XCVR_DATA: assert property (
		!addr_strobe_n && ctl_oe |=> !xcvr_en_n) else $error("no transceiver enable");
	// Ready reaches the far end two cycles late, so look two back
	AST_WAIT_STATE: assert property (
		!xcvr_en_n && ready_n && $past(ready_n) && $past(ready_n, 2)
		|=> !xcvr_en_n && addr_strobe_n) else $error("left data state without ready");
	AST_GRANT_EDGE: assert property (
		$rose(hold_grant) |-> $past(xcvr_en_n) || !$past(ready_n, 3))
		else $error("grant inside a transfer");
	AST_GRANT_DROP: assert property (
		hold_grant && !hold_req |-> ##[1:4] !hold_grant) else $error("grant not dropped");
	AST_RESET_QUIET: assert property (
		bus_reset && $past(bus_reset, 2) && $past(bus_reset, 3)
		|-> !ad_oe && !lane_oe && !ctl_oe && !hold_grant) else $error("driven in reset");
endmodule : lbh_assertions

// ---- tb/lbh_tb.sv ----
// Bench: both ends joined, requests pushed through the FIFO.
// Assumes 100 MHz clock; bus reset runs its full minimum length.
module lbh_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lbh_pkg::*;
	logic clk = 0, rst = 1, rv = 0, hw = 0, fe = 0, is = 1, iq = 0, chk_la = 0;
	logic [REQ_W-1:0] rd = '0, m, d;
	logic [31:0] rw = '0, seed = 32'h2e;
	wire rr, dn, ba, im, irqz, ho, ws;
	wire [31:0] rdat, wd;
	wire [1:0] la;
	logic [REQ_W-1:0] mq[$], dq[$];
	int failures = 0, checks_done = 0, cyc = 0, rem = 0;
	lbh_if bus_if();
	lbh_proc lbh_proc_inst (.CLK_SYS(clk), .RST(rst), .REQ_VALID(rv), .REQ_READY(rr),
		.REQ_DATA(rd), .DONE(dn), .RDATA(rdat), .BAD_ACCESS(ba), .INIT_MASTER(im),
		.IRQ_ZERO(irqz), .BUS(bus_if));
	lbh_agent #(.WAITS(2)) lbh_agent_inst (.CLK_SYS(clk), .RST(rst),
		.HOLD_WANT(hw), .HOLD_OWNED(ho), .FLAG_ERROR(fe), .INIT_SELF(is),
		.IRQ_ZERO_REQ(iq), .READ_WORD(rw), .WR_STROBE(ws), .WR_DATA(wd),
		.LOW_ADDR(la), .BUS(bus_if));
	lbh_assertions lbh_assertions_inst (.CLK_SYS(clk), .RST(rst), .ad_oe(bus_if.ad_oe),
		.lane_sel_n(bus_if.lane_sel_n), .lane_oe(bus_if.lane_oe),
		.addr_strobe_n(bus_if.addr_strobe_n), .xcvr_en_n(bus_if.xcvr_en_n),
		.ctl_oe(bus_if.ctl_oe), .ready_n(bus_if.ready_n), .hold_req(bus_if.hold_req),
		.hold_grant(bus_if.hold_grant), .cacheable_oe(bus_if.cacheable_oe),
		.bus_reset(bus_if.bus_reset));
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	function automatic logic [1:0] low_bit(input logic [3:0] l);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) if (l[i]) r = 2'(i);
		return r;
	endfunction : low_bit
	// Non-contiguous or empty patterns fall back to all lanes
	function automatic logic [3:0] exp_lanes(input logic [3:0] l);
		logic [3:0] s;
		s = l >> low_bit(l);
		return (s == 4'h1 || s == 4'h3 || s == 4'h7 || s == 4'hf) ? l : 4'hf;
	endfunction : exp_lanes
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	task automatic end_sim();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	// Valid stays up between pushes; caller lowers it
	task automatic push(input logic [REQ_W-1:0] r);
		rd = r;
		rv = 1;
		mq.push_back(r);
		dq.push_back(r);
		while (rr !== 1'b1) @(negedge clk);
		@(negedge clk);
	endtask : push
	task automatic drain();
		rv = 0;
		while (dq.size() > 0) @(negedge clk);
		repeat (4) @(negedge clk);
	endtask : drain
	////////////////////////////////////////////////////////////////////////
	// Monitor at the falling edge, where outputs are settled
	always @(negedge clk) begin
		cyc++;
		if (cyc > 6000) begin
			failures++;
			end_sim();
		end
	end
	always @(negedge clk) begin
		if (!rst && !bus_if.addr_strobe_n && bus_if.lane_oe) begin
			if (rem == 0) begin
				m = mq.pop_front();
				cmp("lanes", {28'h0, ~exp_lanes(m[35:32])}, 32'(bus_if.lane_sel_n));
				cmp("cache", 32'(m[39] & ~m[38]), 32'(bus_if.cacheable));
				rem = m[37:36];
			end else begin
				cmp("burst lanes", 32'h0, 32'(bus_if.lane_sel_n));
				rem--;
			end
		end
		if (!rst && dn === 1'b1) begin
			d = dq.pop_front();
			if (!d[40] && d[35:32] == 4'hf) cmp("rdata", rw, rdat);
			cmp("bad", 32'(fe), 32'(ba));
			if (chk_la) cmp("low addr", 32'(low_bit(exp_lanes(d[35:32]))), 32'(la));
		end
		if (!rst && ws === 1'b1 && dq.size() > 0) begin
			cmp("wr dir", 32'h1, 32'(dq[0][40]));
			cmp("wr addr", dq[0][31:0], wd);
		end
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		repeat (RESET_MIN_CYCLES + 6) @(negedge clk);
		cmp("init", 32'h1, 32'(im));
		chk_la = 1;
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			rw = seed;
			push({i[0], i[1], i[2], 2'h0, 4'(i), seed});
			drain();
		end
		chk_la = 0;
		fe = 1;
		push({9'h00f, seed});
		drain();
		fe = 0;
		for (int i = 0; i < 30; i++) begin
			seed = xs(seed);
			if (i % 7 == 3) begin
				// Hold asked between pushes and kept until granted
				rv = 0;
				hw = 1;
				while (ho !== 1'b1) @(negedge clk);
				hw = 0;
			end
			push({seed[31:23], seed});
		end
		drain();
		hw = 1;
		repeat (6) @(negedge clk);
		cmp("grant", 32'h1, 32'(ho));
		for (int i = 0; i < FIFO_DEPTH; i++) push({9'h10f, seed});
		rv = 0;
		cmp("full", 32'h0, 32'(rr));
		hw = 0;
		repeat (5) @(negedge clk);
		cmp("grant off", 32'h0, 32'(ho));
		drain();
		iq = 1;
		repeat (6) @(negedge clk);
		cmp("irq", 32'h1, 32'(irqz));
		// Queue filled under hold so that reset must empty it
		hw = 1;
		repeat (6) @(negedge clk);
		for (int i = 0; i < FIFO_DEPTH; i++) push({9'h03f, seed});
		rv = 0;
		rst = 1;
		hw = 0;
		is = 0;
		repeat (10) @(negedge clk);
		mq.delete();
		dq.delete();
		rem = 0;
		rst = 0;
		repeat (RESET_MIN_CYCLES + 6) @(negedge clk);
		cmp("init", 32'h0, 32'(im));
		cmp("ready", 32'h1, 32'(rr));
		push({9'h00f, seed});
		drain();
		end_sim();
	end
endmodule : lbh_tb

// ---- verilog/lbh_agent.sv ----
// Agent end: memory-like responder, hold requester and reset source.
// Assumes the processor end shares CLK_SYS.
import lbh_pkg::*;

module lbh_agent #(
	parameter int WAITS = 1,
	parameter int RST_LEN = lbh_pkg::RESET_MIN_CYCLES
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// User control
	input wire logic HOLD_WANT,
	output logic HOLD_OWNED,
	input wire logic FLAG_ERROR,
	input wire logic INIT_SELF,
	input wire logic IRQ_ZERO_REQ,
	input wire logic [lbh_pkg::DATA_W-1:0] READ_WORD,
	// Observed transfers
	output logic WR_STROBE,
	output logic [lbh_pkg::DATA_W-1:0] WR_DATA,
	output logic [1:0] LOW_ADDR,
	// Bus
	lbh_if.agent BUS
);
	import lbh_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Reset source: holds bus reset long enough
	logic [5:0] rcnt_reg;
	wire rst_busy = rcnt_reg != 6'(RST_LEN);
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			rcnt_reg <= RST_CNT_INIT;
		end else if (rst_busy) begin
			rcnt_reg <= rcnt_reg + 6'h1;
		end
	end
	// Released on a clock edge, single clock so both edges coincide
	assign BUS.bus_reset = RST || rst_busy;
	assign BUS.irq_zero_n = !IRQ_ZERO_REQ;

	////////////////////////////////////////////////////////////////////////////
	// Responder
	logic [3:0] wcnt_reg;
	logic err_reg, in_xfer_reg;
	wire in_data = !BUS.xcvr_en_n;
	wire rdy = in_data && wcnt_reg == 4'(WAITS);
	assign BUS.ready_n = !rdy;
	assign BUS.rdata = READ_WORD;
	assign BUS.rdata_oe = in_data && !BUS.write_sel;
	// Error reported one cycle after each ready
	assign BUS.bad_access_n = BUS.bus_reset ? INIT_SELF : !err_reg;
	assign BUS.hold_req = HOLD_WANT && !BUS.bus_reset;
	assign HOLD_OWNED = BUS.hold_grant;

	always_ff @(posedge CLK_SYS) begin
		if (BUS.bus_reset) begin
			wcnt_reg <= 4'h0;
			err_reg <= 1'b0;
			in_xfer_reg <= 1'b0;
			WR_STROBE <= 1'b0;
			WR_DATA <= '0;
			LOW_ADDR <= 2'h0;
		end else begin
			wcnt_reg <= (in_data && !rdy) ? wcnt_reg + 4'h1 : 4'h0;
			in_xfer_reg <= in_data;
			err_reg <= rdy && FLAG_ERROR;
			WR_STROBE <= rdy && BUS.write_sel;
			if (rdy) begin
				WR_DATA <= BUS.ad_out;
			end
			if (!BUS.addr_strobe_n) begin
				LOW_ADDR <= lbh_lanes_to_a10(~BUS.lane_sel_n);
			end
		end
	end
endmodule : lbh_agent

// ---- verilog/lbh_fifo.sv ----
// Parameterised FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
module lbh_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg, rd_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem[rd_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : lbh_fifo

// ---- verilog/lbh_if.sv ----
// Bus wires between the processor end and the agent/master end.
// Assumes the bench resolves open-drain and three-state wires from enables.
interface lbh_if;
	import lbh_pkg::*;
	logic [DATA_W-1:0] ad_out, ad_in;
	logic ad_oe;
	logic [LANES-1:0] lane_sel_n;
	logic lane_oe;
	logic addr_strobe_n;
	logic write_sel;
	logic xcvr_en_n;
	logic ctl_oe;
	logic ready_n;
	logic [DATA_W-1:0] rdata;
	logic rdata_oe;
	logic hold_req;
	logic hold_grant;
	logic cacheable;
	logic cacheable_oe;
	logic bad_access_n;
	logic irq_zero_n;
	logic bus_reset;

	modport proc (
		output ad_out, ad_oe, lane_sel_n, lane_oe, addr_strobe_n, write_sel,
		output xcvr_en_n, ctl_oe, hold_grant, cacheable, cacheable_oe,
		input ready_n, rdata, rdata_oe, hold_req, bad_access_n, irq_zero_n, bus_reset
	);
	modport agent (
		input ad_out, ad_oe, lane_sel_n, lane_oe, addr_strobe_n, write_sel,
		input xcvr_en_n, ctl_oe, hold_grant, cacheable, cacheable_oe,
		output ready_n, rdata, rdata_oe, hold_req, bad_access_n, irq_zero_n, bus_reset
	);
endinterface : lbh_if

// ---- verilog/lbh_pkg.sv ----
// Shared constants and types for the local-bus lane/hold/reset link.
// Assumes one system clock shared by both ends.
package lbh_pkg;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int MAX_BURST = 4;
	localparam int RESET_MIN_DOUBLE_RATE_CLOCK = 41;
	localparam int DOUBLE_RATE_CLOCK_PER_SYS = 1;
	localparam int RESET_MIN_CYCLES = (RESET_MIN_DOUBLE_RATE_CLOCK + DOUBLE_RATE_CLOCK_PER_SYS - 1) / DOUBLE_RATE_CLOCK_PER_SYS;
	localparam logic [3:0] LANES_NONE = 4'h0;
	localparam logic [3:0] LANES_ALL = 4'hf;
	localparam logic [5:0] RST_CNT_INIT = 6'h00;
	typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_HOLD} lbh_state_e;
	// Request word: {write, cacheable, sync, count-1, lanes, address}
	localparam int REQ_W = 1 + 1 + 1 + 2 + LANES + DATA_W;

	// True when asserted lanes are contiguous and non-empty
	function automatic logic lbh_lanes_ok(input logic [3:0] l);
		case (l)
			4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf: lbh_lanes_ok = 1'b1;
			default: lbh_lanes_ok = 1'b0;
		endcase
	endfunction : lbh_lanes_ok

	// Recover the two low address bits from lane pattern
	function automatic logic [1:0] lbh_lanes_to_a10(input logic [3:0] l);
		if (l[0]) begin
			lbh_lanes_to_a10 = 2'h0;
		end else if (l[1]) begin
			lbh_lanes_to_a10 = 2'h1;
		end else if (l[2]) begin
			lbh_lanes_to_a10 = 2'h2;
		end else begin
			lbh_lanes_to_a10 = 2'h3;
		end
	endfunction : lbh_lanes_to_a10
endpackage : lbh_pkg

// ---- verilog/lbh_proc.sv ----
// Processor end of the local bus: lane selects, hold handover, cacheable flag,
// bad-access sampling and reset handling. Requests enter through an 8-word FIFO.
// Assumes the agent end shares CLK_SYS; bus inputs other than rdata and rdata_oe are still double-synchronised.
import lbh_pkg::*;

// Overview of operation
// - Lane 3 is bits 31:24, lane 0 bits 7:0
// - Address state shows first word's lanes
// - Data state shows next word's lanes
// - Lanes held through cycles without ready
// - Read lanes show bytes actually consumed
// - Lane patterns contiguous, never empty
// - Agent decodes low address bits from lanes
// - Hold granted: float lines, assert grant
// - Hold removed: drop grant, idle or address
// - Cacheable asserted in address state when allowed
// - Cacheable never set for synchronous accesses
// - Cacheable floats while idle
// - Bad access sampled cycle after final ready
// - Bad access during reset selects initializer
// - Reset clears all logic, restarts initialization; the input synchroniser flops are not reset
// - In reset: ignore inputs, float, deassert
// - Reset held at least 41 clock cycles
// - Release reset just after both clock edges
// - No ready: wait state, no address strobe
// - Strobe each address state, again after ready
// - Transceiver enable low in data, wait states
module lbh_proc #(
	parameter int FIFO_W = lbh_pkg::REQ_W,
	parameter int FIFO_D = lbh_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Request stream
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic [FIFO_W-1:0] REQ_DATA,
	// Completion
	output logic DONE,
	output logic [lbh_pkg::DATA_W-1:0] RDATA,
	output logic BAD_ACCESS,
	output logic INIT_MASTER,
	output logic IRQ_ZERO,
	// Bus
	lbh_if.proc BUS
);
	import lbh_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers: first stage read only by the second
	logic rdy_s1, rdy_s2, hold_s1, hold_s2, bad_s1, bad_s2, irq_s1, irq_s2;
	always_ff @(posedge CLK_SYS) begin
		rdy_s1 <= BUS.ready_n;
		rdy_s2 <= rdy_s1;
		hold_s1 <= BUS.hold_req;
		hold_s2 <= hold_s1;
		bad_s1 <= BUS.bad_access_n;
		bad_s2 <= bad_s1;
		irq_s1 <= BUS.irq_zero_n;
		irq_s2 <= irq_s1;
	end

	// Bus reset also comes from the agent end; OR with local reset
	logic brst_s1, brst_s2;
	always_ff @(posedge CLK_SYS) begin
		brst_s1 <= BUS.bus_reset;
		brst_s2 <= brst_s1;
	end
	wire rst_any = RST || brst_s2;
	wire ready_seen = !rdy_s2;

	////////////////////////////////////////////////////////////////////////////
	// Request FIFO
	logic q_valid, q_take;
	logic [FIFO_W-1:0] q_data;
	lbh_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
		.clk(CLK_SYS),
		.rst(rst_any),
		.in_valid(REQ_VALID),
		.in_ready(REQ_READY),
		.in_data(REQ_DATA),
		.out_valid(q_valid),
		.out_ready(q_take),
		.out_data(q_data)
	);

	// Field split of a queued request
	wire q_write = q_data[FIFO_W-1];
	wire q_cache = q_data[FIFO_W-2];
	wire q_sync = q_data[FIFO_W-3];
	wire [1:0] q_cnt = q_data[FIFO_W-4 -: 2];
	wire [LANES-1:0] q_lanes = q_data[DATA_W +: LANES];
	wire [DATA_W-1:0] q_addr = q_data[DATA_W-1:0];
	// Bad patterns replaced by full word rather than driving illegal lanes
	wire [LANES-1:0] q_lanes_fix = lbh_lanes_ok(q_lanes) ? q_lanes : LANES_ALL;

	////////////////////////////////////////////////////////////////////////////
	// Bus state machine
	lbh_state_e st_reg, st_next;
	logic [1:0] left_reg;
	logic write_reg, cache_reg;
	logic [LANES-1:0] lanes_reg;
	logic [DATA_W-1:0] addr_reg;
	logic chk_reg;

	wire start = q_valid && !hold_s2;
	wire last_ready = (st_reg == ST_DATA) && ready_seen && (left_reg == 2'h0);
	assign q_take = (st_reg == ST_IDLE || st_reg == ST_HOLD || last_ready) && start;

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: begin
				if (hold_s2) begin
					st_next = ST_HOLD;
				end else if (q_valid) begin
					st_next = ST_ADDR;
				end
			end
			ST_ADDR: st_next = ST_DATA;
			ST_DATA: begin
				if (last_ready) begin
					// Boundary only: grant hold before next transaction
					st_next = hold_s2 ? ST_HOLD : (q_valid ? ST_ADDR : ST_IDLE);
				end
			end
			ST_HOLD: begin
				if (!hold_s2) begin
					st_next = q_valid ? ST_ADDR : ST_IDLE;
				end
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (rst_any) begin
			st_reg <= ST_IDLE;
			left_reg <= 2'h0;
			write_reg <= 1'b0;
			cache_reg <= 1'b0;
			lanes_reg <= LANES_NONE;
			addr_reg <= '0;
		end else begin
			st_reg <= st_next;
			if (st_next == ST_ADDR && st_reg != ST_ADDR) begin
				left_reg <= q_cnt;
				write_reg <= q_write;
				cache_reg <= q_cache && !q_sync;
				lanes_reg <= q_lanes_fix;
				addr_reg <= q_addr;
			end else if (st_reg == ST_ADDR && left_reg != 2'h0) begin
				// Data state already shows the next burst word's lanes
				lanes_reg <= LANES_ALL;
			end else if (st_reg == ST_DATA && ready_seen && left_reg != 2'h0) begin
				left_reg <= left_reg - 2'h1;
				// Burst words after the first use all lanes
				lanes_reg <= LANES_ALL;
			end
		end
	end
	// Without ready in the data state the lane register is untouched

	////////////////////////////////////////////////////////////////////////////
	// Bus outputs
	wire drive = !rst_any && (st_reg == ST_ADDR || st_reg == ST_DATA);
	wire burst_strobe = (st_reg == ST_DATA) && ready_seen && (left_reg != 2'h0);
	assign BUS.addr_strobe_n = !(drive && (st_reg == ST_ADDR || burst_strobe));
	assign BUS.xcvr_en_n = !(drive && st_reg == ST_DATA);
	assign BUS.lane_sel_n = drive ? ~lanes_reg : ~LANES_NONE;
	assign BUS.lane_oe = drive;
	assign BUS.ctl_oe = drive;
	assign BUS.write_sel = drive && write_reg;
	assign BUS.ad_out = addr_reg;
	assign BUS.ad_oe = drive;
	assign BUS.hold_grant = !rst_any && st_reg == ST_HOLD;
	assign BUS.cacheable = cache_reg && st_reg == ST_ADDR;
	assign BUS.cacheable_oe = drive;

	////////////////////////////////////////////////////////////////////////////
	// Completion, bad-access sample and initializer strap
	always_ff @(posedge CLK_SYS) begin
		if (rst_any) begin
			chk_reg <= 1'b0;
			DONE <= 1'b0;
			RDATA <= '0;
			BAD_ACCESS <= 1'b0;
			IRQ_ZERO <= 1'b0;
		end else begin
			chk_reg <= last_ready;
			DONE <= chk_reg;
			if (last_ready && BUS.rdata_oe) begin
				RDATA <= BUS.rdata;
			end
			BAD_ACCESS <= chk_reg && !bad_s2;
			IRQ_ZERO <= !irq_s2;
		end
	end

	// Strap caught by clocked logic while reset is held
	// Value of the last reset cycle is kept until the next reset
	always_ff @(posedge CLK_SYS) begin
		if (rst_any) begin
			INIT_MASTER <= bad_s2;
		end
	end
endmodule : lbh_proc
